// ==== rom_cmd_pkg.sv ====
package rom_cmd_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;

  // Network command codes, eight bits each.
  localparam logic [7:0] CMD_SEARCH     = 8'hF0;
  localparam logic [7:0] CMD_READ_ID    = 8'h33;
  localparam logic [7:0] CMD_MATCH      = 8'h55;
  localparam logic [7:0] CMD_SKIP       = 8'hCC;
  localparam logic [7:0] CMD_RESUME     = 8'hA5;
  localparam logic [7:0] CMD_FAST_SKIP  = 8'h3C;
  localparam logic [7:0] CMD_FAST_MATCH = 8'h69;

  localparam int unsigned ID_BITS  = 64;
  localparam int unsigned CNT_W    = 16;
  localparam logic [7:0]  CRC_POLY = 8'h8C;

  // Line times in nanoseconds.
  localparam int unsigned SPEED_CLEAR_NS = 480_000;
  localparam int unsigned RST_STD_NS     = 240_000;
  localparam int unsigned RST_FAST_NS    = 48_000;
  localparam int unsigned PDH_STD_NS     = 30_000;
  localparam int unsigned PDH_FAST_NS    = 3_000;
  localparam int unsigned PDL_STD_NS     = 120_000;
  localparam int unsigned PDL_FAST_NS    = 12_000;
  localparam int unsigned MID_STD_NS     = 30_000;
  localparam int unsigned MID_FAST_NS    = 3_000;
  localparam int unsigned LPF_NS         = 500;
  localparam int unsigned REH_NS         = 1_000;

  // Least times, rounded up to whole clock cycles.
  localparam int unsigned SPEED_CLEAR_CYC_DEF = (SPEED_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_STD_CYC_DEF     = (RST_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PDL_STD_CYC_DEF     = (PDL_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_FAST_CYC        = (RST_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PDH_STD_CYC         = (PDH_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PDH_FAST_CYC        = (PDH_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PDL_FAST_CYC        = (PDL_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MID_STD_CYC         = (MID_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MID_FAST_CYC        = (MID_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LPF_CYC             = (LPF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REH_CYC             = (REH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_PWAIT  = 8'h02,
    ST_PRES   = 8'h04,
    ST_CMD    = 8'h08,
    ST_READID = 8'h10,
    ST_SEARCH = 8'h20,
    ST_MATCH  = 8'h40,
    ST_FUNC   = 8'h80
  } state_e;

  // Check byte over family and serial fields, fed least significant bit first.
  function automatic logic [7:0] crc8_56(input logic [55:0] d);
    logic [7:0] c;
    logic       fb;
    c  = 8'h00;
    fb = 1'b0;
    for (int i = 0; i < 56; i++) begin
      fb = c[0] ^ d[i];
      c  = {1'b0, c[7:1]};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction

endpackage

// ==== line_filter.sv ====
`timescale 1ns/1ps
`default_nettype none

// Cleans the sampled bus level before slot timing sees it.
module line_filter #(
  parameter int unsigned LPF_CYC = rom_cmd_pkg::LPF_CYC,
  parameter int unsigned REH_CYC = rom_cmd_pkg::REH_CYC
) (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic dq_i,
  input  wire logic fast_i,
  output logic      line_o
);

  logic       line_q;
  logic [7:0] lpf_cnt_q;
  logic [7:0] reh_cnt_q;

  // A low must persist before it counts as a fall, except in fast mode. [R15]
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lpf_cnt_q <= 8'h00;
    end else if (dq_i) begin
      lpf_cnt_q <= 8'h00;
    end else if (lpf_cnt_q != 8'hFF) begin
      lpf_cnt_q <= lpf_cnt_q + 8'h01;
    end
  end

  // Hold-off window opens on every rise of the cleaned level.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reh_cnt_q <= 8'h00;
    end else if (!line_q && dq_i) begin
      reh_cnt_q <= 8'(REH_CYC);
    end else if (reh_cnt_q != 8'h00) begin
      reh_cnt_q <= reh_cnt_q - 8'h01;
    end
  end

  // Lows inside the window are ignored; one still present when it closes is a fall. [R16]
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      line_q <= 1'b1;
    end else if (line_q) begin
      if (!dq_i && reh_cnt_q == 8'h00 && (fast_i || lpf_cnt_q >= 8'(LPF_CYC - 1))) begin
        line_q <= 1'b0;
      end
    end else if (dq_i) begin
      line_q <= 1'b1;
    end
  end

  assign line_o = line_q;

endmodule

`default_nettype wire

// ==== byte_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             full;
  logic             empty;

  assign full        = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty       = (wr_q == rd_q);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rd_q[AW-1:0]];

  always_ff @(posedge mclk_i) begin
    if (in_valid_i && !full) begin
      mem[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= '0;
    end else if (in_valid_i && !full) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_q <= '0;
    end else if (out_ready_i && !empty) begin
      rd_q <= rd_q + 1'b1;
    end
  end

endmodule

`default_nettype wire

// ==== rom_command_layer.sv ====
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: Search handles each identifier bit, LSB first, as true, complement, then master choice.
// R2: On a search choice differing from own bit, drop out of the pass.
// R3: Read-identifier sends family byte, 48-bit serial, then check byte over both.
// R4: Master uses read-identifier only with a single device attached.
// R5: Match takes 64 bits; only exact match proceeds, else idle until reset.
// R6: Skip goes straight to function commands with no identifier bits.
// R7: Resume proceeds like skip only while the reselect flag is set.
// R8: Reselect flag is set only by successful match, search or fast match.
// R9: Selecting any other device clears the reselect flag.
// R10: Fast skip sets the speed flag and proceeds to function commands.
// R11: After multidrop fast skip, master sends fast reset then match or search.
// R12: Fast match receives identifier at fast speed; exact match sets fast mode.
// R13: A device already fast stays fast when a fast match misses it.
// R14: Any reset low of 480 us or more clears the speed flag.
// R15: Falling-edge filtering applies at standard speed only.
// R16: Lows ending inside the hold-off window are ignored; longer lows open slots.
// R17: Commands are eight bits and follow a reset and presence.
// R18: Standard speed is the default; only fast commands set fast speed.
// R19: A short fast-speed reset resets the device but keeps fast speed.
// R20: Commands and identifiers move LSB first, one bit per slot.
module rom_command_layer #(
  parameter int unsigned SPEED_CLEAR_CYC = rom_cmd_pkg::SPEED_CLEAR_CYC_DEF,
  parameter int unsigned RST_STD_CYC     = rom_cmd_pkg::RST_STD_CYC_DEF,
  parameter int unsigned PDL_STD_CYC     = rom_cmd_pkg::PDL_STD_CYC_DEF,
  parameter int unsigned FIFO_DEPTH      = 8
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        dq_i,
  output logic             dq_o,
  output logic             dq_oe_o,
  input  wire logic [7:0]  family_i,
  input  wire logic [47:0] serial_i,
  output logic [7:0]       func_data_o,
  output logic             func_valid_o,
  input  wire logic        func_ready_i,
  output logic             selected_o,
  output logic             fast_speed_flag_o,
  output logic             reselect_flag_o,
  output logic             overflow_o
);

  localparam int unsigned CW = rom_cmd_pkg::CNT_W;

  rom_cmd_pkg::state_e state_q;

  logic          line;
  logic          line_d1_q;
  logic          fall;
  logic          rise;
  logic [CW-1:0] low_cnt_q;
  logic [CW-1:0] tmr_q;
  logic [CW-1:0] rst_thr;
  logic [CW-1:0] pdh_cyc;
  logic [CW-1:0] pdl_cyc;
  logic [CW-1:0] mid_cyc;
  logic          reset_det;
  logic          slot_q;
  logic          bit_ev;
  logic          drive_q;
  logic [5:0]    idx_q;
  logic [1:0]    sub_q;
  logic [7:0]    sh_q;
  logic [7:0]    cmd_byte;
  logic          cmd_done;
  logic          id_last;
  logic [63:0]   uid;
  logic          uid_bit;
  logic          want_tx;
  logic          tx_bit;
  logic          search_fail;
  logic          search_ok;
  logic          match_fail;
  logic          match_ok;
  logic          fast_q;
  logic          fast_match_q;
  logic          fast_prev_q;
  logic          reselect_q;
  logic          pend_q;
  logic [7:0]    pend_data_q;
  logic          fifo_in_ready;
  logic          stall;
  logic          func_byte;
  logic          overflow_q;
  logic          slot_state;

  line_filter u_filter (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .dq_i   (dq_i),
    .fast_i (fast_q),
    .line_o (line)
  );

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .in_valid_i  (pend_q),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (pend_data_q),
    .out_valid_o (func_valid_o),
    .out_ready_i (func_ready_i),
    .out_data_o  (func_data_o)
  );

  // The check byte is rebuilt from the fields so that it always agrees with them.
  assign uid = {rom_cmd_pkg::crc8_56({serial_i, family_i}), serial_i, family_i}; // [R3]

  assign fall = line_d1_q && !line;
  assign rise = !line_d1_q && line;

  assign rst_thr = fast_q ? CW'(rom_cmd_pkg::RST_FAST_CYC) : CW'(RST_STD_CYC);
  assign pdh_cyc = fast_q ? CW'(rom_cmd_pkg::PDH_FAST_CYC) : CW'(rom_cmd_pkg::PDH_STD_CYC);
  assign pdl_cyc = fast_q ? CW'(rom_cmd_pkg::PDL_FAST_CYC) : CW'(PDL_STD_CYC);
  assign mid_cyc = fast_q ? CW'(rom_cmd_pkg::MID_FAST_CYC) : CW'(rom_cmd_pkg::MID_STD_CYC);

  // Our own presence low must never be taken for a master reset.
  assign reset_det = rise && (low_cnt_q >= rst_thr) && (state_q != rom_cmd_pkg::ST_PRES);

  assign slot_state = (state_q == rom_cmd_pkg::ST_CMD) || (state_q == rom_cmd_pkg::ST_READID) ||
                      (state_q == rom_cmd_pkg::ST_SEARCH) || (state_q == rom_cmd_pkg::ST_MATCH) ||
                      (state_q == rom_cmd_pkg::ST_FUNC);

  assign bit_ev  = slot_q && (tmr_q == mid_cyc);
  assign id_last = (idx_q == 6'h3F);
  assign uid_bit = uid[idx_q];

  assign want_tx = (state_q == rom_cmd_pkg::ST_READID) ||
                   ((state_q == rom_cmd_pkg::ST_SEARCH) && (sub_q != 2'h2));
  assign tx_bit  = (state_q == rom_cmd_pkg::ST_SEARCH && sub_q == 2'h1) ? !uid_bit : uid_bit; // [R1]

  // Received bits enter at the top, so the first bit ends up as bit 0. [R20]
  assign cmd_byte = {line, sh_q[7:1]};
  assign cmd_done = bit_ev && (state_q == rom_cmd_pkg::ST_CMD) && (idx_q[2:0] == 3'h7); // [R17]

  assign search_fail = bit_ev && (state_q == rom_cmd_pkg::ST_SEARCH) && (sub_q == 2'h2) && (line != uid_bit);
  assign search_ok   = bit_ev && (state_q == rom_cmd_pkg::ST_SEARCH) && (sub_q == 2'h2) &&
                       (line == uid_bit) && id_last;
  assign match_fail  = bit_ev && (state_q == rom_cmd_pkg::ST_MATCH) && (line != uid_bit);
  assign match_ok    = bit_ev && (state_q == rom_cmd_pkg::ST_MATCH) && (line == uid_bit) && id_last;

  // A full buffer stalls byte assembly; bits arriving meanwhile are lost and flagged.
  assign stall     = pend_q && !fifo_in_ready;
  assign func_byte = bit_ev && (state_q == rom_cmd_pkg::ST_FUNC) && !stall && (idx_q[2:0] == 3'h7);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      line_d1_q <= 1'b1;
    end else begin
      line_d1_q <= line;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt_q <= '0;
    end else if (line) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != {CW{1'b1}}) begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end

  // One timer serves presence timing and slot timing; it restarts on each event.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tmr_q <= '0;
    end else if (reset_det || fall || (state_q == rom_cmd_pkg::ST_PWAIT && tmr_q == pdh_cyc)) begin
      tmr_q <= '0;
    end else if (tmr_q != {CW{1'b1}}) begin
      tmr_q <= tmr_q + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      slot_q <= 1'b0;
    end else if (reset_det) begin
      slot_q <= 1'b0;
    end else if (fall && slot_state) begin
      slot_q <= 1'b1;
    end else if (bit_ev) begin
      slot_q <= 1'b0;
    end
  end

  // Pull-down for presence and for zero bits sent to the master.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_q <= 1'b0;
    end else if (state_q == rom_cmd_pkg::ST_PWAIT && tmr_q == pdh_cyc) begin
      drive_q <= 1'b1;
    end else if (state_q == rom_cmd_pkg::ST_PRES && tmr_q == pdl_cyc) begin
      drive_q <= 1'b0;
    end else if (fall && want_tx && !tx_bit) begin
      drive_q <= 1'b1; // [R1] [R3]
    end else if (state_q != rom_cmd_pkg::ST_PRES && (tmr_q == mid_cyc || reset_det)) begin
      drive_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= rom_cmd_pkg::ST_IDLE;
    end else if (reset_det) begin
      state_q <= rom_cmd_pkg::ST_PWAIT;
    end else begin
      unique case (state_q)
        rom_cmd_pkg::ST_IDLE: begin
          state_q <= rom_cmd_pkg::ST_IDLE; // [R5]
        end
        rom_cmd_pkg::ST_PWAIT: begin
          if (tmr_q == pdh_cyc) begin
            state_q <= rom_cmd_pkg::ST_PRES;
          end
        end
        rom_cmd_pkg::ST_PRES: begin
          if (tmr_q == pdl_cyc) begin
            state_q <= rom_cmd_pkg::ST_CMD; // [R17]
          end
        end
        rom_cmd_pkg::ST_CMD: begin
          if (cmd_done) begin
            unique case (cmd_byte)
              rom_cmd_pkg::CMD_SEARCH:     state_q <= rom_cmd_pkg::ST_SEARCH;
              rom_cmd_pkg::CMD_READ_ID:    state_q <= rom_cmd_pkg::ST_READID; // [R3]
              rom_cmd_pkg::CMD_MATCH:      state_q <= rom_cmd_pkg::ST_MATCH;
              rom_cmd_pkg::CMD_FAST_MATCH: state_q <= rom_cmd_pkg::ST_MATCH;
              rom_cmd_pkg::CMD_SKIP:       state_q <= rom_cmd_pkg::ST_FUNC; // [R6]
              rom_cmd_pkg::CMD_FAST_SKIP:  state_q <= rom_cmd_pkg::ST_FUNC; // [R10]
              rom_cmd_pkg::CMD_RESUME: begin
                state_q <= reselect_q ? rom_cmd_pkg::ST_FUNC : rom_cmd_pkg::ST_IDLE; // [R7]
              end
              default:                     state_q <= rom_cmd_pkg::ST_IDLE;
            endcase
          end
        end
        rom_cmd_pkg::ST_READID: begin
          if (bit_ev && id_last) begin
            state_q <= rom_cmd_pkg::ST_FUNC;
          end
        end
        rom_cmd_pkg::ST_SEARCH: begin
          if (search_fail) begin
            state_q <= rom_cmd_pkg::ST_IDLE; // [R2]
          end else if (search_ok) begin
            state_q <= rom_cmd_pkg::ST_FUNC;
          end
        end
        rom_cmd_pkg::ST_MATCH: begin
          if (match_fail) begin
            state_q <= rom_cmd_pkg::ST_IDLE; // [R5]
          end else if (match_ok) begin
            state_q <= rom_cmd_pkg::ST_FUNC; // [R5] [R12]
          end
        end
        rom_cmd_pkg::ST_FUNC: begin
          state_q <= rom_cmd_pkg::ST_FUNC;
        end
        default: begin
          state_q <= rom_cmd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Bit position: command bits count in the low three bits, identifier bits in all six.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      idx_q <= 6'h00;
      sub_q <= 2'h0;
    end else if (reset_det || cmd_done) begin
      idx_q <= 6'h00;
      sub_q <= 2'h0;
    end else if (bit_ev) begin
      if (state_q == rom_cmd_pkg::ST_SEARCH) begin
        if (sub_q == 2'h2) begin
          sub_q <= 2'h0;
          idx_q <= idx_q + 6'h01; // [R1] [R20]
        end else begin
          sub_q <= sub_q + 2'h1;
        end
      end else if (state_q != rom_cmd_pkg::ST_FUNC || !stall) begin
        idx_q <= idx_q + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sh_q <= 8'h00;
    end else if (bit_ev && (state_q == rom_cmd_pkg::ST_CMD || (state_q == rom_cmd_pkg::ST_FUNC && !stall))) begin
      sh_q <= cmd_byte; // [R20]
    end
  end

  // Speed flag starts standard; only the two fast commands raise it. [R18]
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fast_q       <= 1'b0;
      fast_match_q <= 1'b0;
      fast_prev_q  <= 1'b0;
    end else if (reset_det) begin
      fast_match_q <= 1'b0;
      if (low_cnt_q >= CW'(SPEED_CLEAR_CYC)) begin
        fast_q <= 1'b0; // [R14] [R19]
      end
    end else if (cmd_done && cmd_byte == rom_cmd_pkg::CMD_FAST_SKIP) begin
      fast_q <= 1'b1; // [R10]
    end else if (cmd_done && cmd_byte == rom_cmd_pkg::CMD_FAST_MATCH) begin
      fast_prev_q  <= fast_q;
      fast_match_q <= 1'b1;
      fast_q       <= 1'b1; // [R12]
    end else if (match_fail && fast_match_q) begin
      fast_q <= fast_prev_q; // [R13]
    end
  end

  // Search, match, fast match, skip and fast skip clear the flag; a completed selection sets it, set winning.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reselect_q <= 1'b0;
    end else if (search_ok || match_ok) begin
      reselect_q <= 1'b1; // [R8]
    end else if (cmd_done && (cmd_byte == rom_cmd_pkg::CMD_SEARCH || cmd_byte == rom_cmd_pkg::CMD_MATCH ||
                              cmd_byte == rom_cmd_pkg::CMD_FAST_MATCH || cmd_byte == rom_cmd_pkg::CMD_SKIP ||
                              cmd_byte == rom_cmd_pkg::CMD_FAST_SKIP)) begin
      reselect_q <= 1'b0; // [R9]
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_q      <= 1'b0;
      pend_data_q <= 8'h00;
    end else if (func_byte) begin
      pend_q      <= 1'b1;
      pend_data_q <= cmd_byte;
    end else if (pend_q && fifo_in_ready) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      overflow_q <= 1'b0;
    end else if (bit_ev && state_q == rom_cmd_pkg::ST_FUNC && stall) begin
      overflow_q <= 1'b1;
    end else if (reset_det) begin
      overflow_q <= 1'b0;
    end
  end

  assign dq_o              = 1'b0;
  assign dq_oe_o           = drive_q;
  assign selected_o        = (state_q == rom_cmd_pkg::ST_FUNC);
  assign fast_speed_flag_o = fast_q;
  assign reselect_flag_o   = reselect_q;
  assign overflow_o        = overflow_q;

endmodule

`default_nettype wire

// ==== rom_cmd_layer_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module rom_cmd_layer_sva #(
  parameter int unsigned SPEED_CLEAR_CYC = 24000,
  parameter int unsigned RST_STD_CYC     = 12000
) (
  input wire logic       mclk_i,
  input wire logic       rst_i,
  input wire logic       dq_i,
  input wire logic       dq_oe_o,
  input wire logic [7:0] func_data_o,
  input wire logic       func_valid_o,
  input wire logic       func_ready_i,
  input wire logic       selected_o,
  input wire logic       fast_speed_flag_o,
  input wire logic       reselect_flag_o,
  input wire logic       overflow_o
);
  logic [15:0] low_q;
  logic [15:0] oe_q;
  logic        dq_q;
  logic [15:0] pw_q;
  logic        pres_q;
  // Length of the current low, or of the last one while the line is high.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      low_q <= 16'h0000;
      dq_q  <= 1'b1;
    end else begin
      dq_q <= dq_i;
      if (!dq_i) begin
        low_q <= dq_q ? 16'h0001 : low_q + 16'h0001;
      end
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      oe_q <= 16'h0000;
    end else begin
      oe_q <= dq_oe_o ? oe_q + 16'h0001 : 16'h0000;
    end
  end
  // Cycles since a standard-speed bus reset ended; the delay is too long for a delay range.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pw_q   <= 16'h0000;
      pres_q <= 1'b0;
    end else if (dq_i && !dq_q && low_q >= RST_STD_CYC && !fast_speed_flag_o) begin
      pw_q   <= 16'h0001;
      pres_q <= 1'b0;
    end else if (pw_q != 16'h0000 && pw_q < 16'h05F2) begin
      pw_q   <= pw_q + 16'h0001;
      pres_q <= pres_q || (dq_oe_o && oe_q == 16'h0000 && pw_q >= 16'h05D2);
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_rst_quiet;
    disable iff (1'b0) rst_i |-> !dq_oe_o && !selected_o && !fast_speed_flag_o && !reselect_flag_o
      && !func_valid_o && !overflow_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("output active in reset");
  property p_presence;
    pw_q == 16'h05F1 |-> pres_q;
  endproperty
  a_presence: assert property (p_presence) else $error("no presence pulse");
  property p_drive_short;
    oe_q <= 16'h0640;
  endproperty
  a_drive_short: assert property (p_drive_short) else $error("line held too long");
  property p_speed_clear;
    $rose(dq_i) && low_q >= SPEED_CLEAR_CYC |-> ##[0:20] !fast_speed_flag_o;
  endproperty
  a_speed_clear: assert property (p_speed_clear) else $error("speed not cleared");
  property p_speed_keep;
    $rose(dq_i) && fast_speed_flag_o && low_q >= rom_cmd_pkg::RST_FAST_CYC && low_q < SPEED_CLEAR_CYC
      |=> fast_speed_flag_o [*8];
  endproperty
  a_speed_keep: assert property (p_speed_keep) else $error("speed lost");
  property p_sel_drop;
    $fell(selected_o) |-> low_q >= RST_STD_CYC;
  endproperty
  a_sel_drop: assert property (p_sel_drop) else $error("deselected without reset");
  property p_resel_sel;
    $rose(reselect_flag_o) |-> ##[0:4] selected_o;
  endproperty
  a_resel_sel: assert property (p_resel_sel) else $error("reselect without selection");
  property p_fifo_hold;
    func_valid_o && !func_ready_i && low_q < RST_STD_CYC |=> func_valid_o && $stable(func_data_o);
  endproperty
  a_fifo_hold: assert property (p_fifo_hold) else $error("buffer output changed");
  property p_ovf_full;
    $rose(overflow_o) |-> func_valid_o;
  endproperty
  a_ovf_full: assert property (p_ovf_full) else $error("overflow with room");
endmodule
`default_nettype wire

// ==== line_master.sv ====
`timescale 1ns/1ps
`default_nettype none
// Bus master: the line is pulled up, so releasing it reads high.
module line_master (
  input  wire logic mclk_i,
  input  wire logic dq_i,
  output logic      low_o
);
  bit fast = 1'b0;
  initial low_o = 1'b0;
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic bus_reset(input int n, output bit pres);
    pres = 1'b0;
    low_o = 1'b1;
    tick(n);
    low_o = 1'b0;
    repeat (fast ? 850 : 1700) begin
      tick(1);
      if (dq_i === 1'b0) pres = 1'b1;
    end
  endtask
  // A one is a short low that also serves as a read slot.
  task automatic slot(input bit b, output bit r);
    int l;
    int s;
    l = b ? (fast ? 5 : 40) : (fast ? 170 : 1600);
    s = fast ? 100 : 1000;
    low_o = 1'b1;
    tick(l);
    low_o = 1'b0;
    if (s > l) tick(s - l);
    r = dq_i;
    tick((fast ? 230 : 1700) - (s > l ? s : l));
  endtask
endmodule
`default_nettype wire

// ==== single_wire_rom_command_layer_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module single_wire_rom_command_layer_test;
  function automatic logic [7:0] crc_of(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) c = {1'b0, c[7:1]} ^ ((c[0] ^ d[i]) ? rom_cmd_pkg::CRC_POLY : 8'h00);
    return c;
  endfunction
  localparam logic [7:0]  FAMILY = 8'hA7; // Arbitrary value.
  localparam logic [47:0] SERIAL = 48'h1234_5678_9ABC;
  localparam logic [63:0] ID     = {crc_of({SERIAL, FAMILY}), SERIAL, FAMILY};
  logic       mclk_i = 1'b0;
  logic       rst_i = 1'b0;
  logic       ready = 1'b0;
  logic       low;
  logic       dq_o, dq_oe_o, valid, sel, fast, resel, ovf;
  logic [7:0] data;
  wire logic  dq = !(low || (dq_oe_o && !dq_o));
  int         n_mismatch = 0;
  int         n_tests = 0;
  bit         p, a, b;
  always #10 mclk_i = !mclk_i;
  line_master m (.mclk_i(mclk_i), .dq_i(dq), .low_o(low));
  rom_command_layer #(.SPEED_CLEAR_CYC(3000), .RST_STD_CYC(2000), .PDL_STD_CYC(60)) uut (
    .mclk_i(mclk_i), .rst_i(rst_i), .dq_i(dq), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .family_i(FAMILY),
    .serial_i(SERIAL), .func_data_o(data), .func_valid_o(valid), .func_ready_i(ready), .selected_o(sel),
    .fast_speed_flag_o(fast), .reselect_flag_o(resel), .overflow_o(ovf));
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic results;
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic send(input logic [7:0] v);
    for (int i = 0; i < 8; i++) m.slot(v[i], a);
  endtask
  task automatic fast_reset;
    m.bus_reset(2450, p);
    chk(p, 1);
  endtask
  task automatic t_fast_skip;
    m.bus_reset(2100, p);
    chk(p, 1);
    send(rom_cmd_pkg::CMD_FAST_SKIP);
    chk({fast, sel}, 2'b11);
    m.fast = 1'b1;
  endtask
  // The far side stalls while nine bytes arrive; the first bit of a tenth byte finds no room.
  task automatic t_fifo;
    for (int k = 0; k < 9; k++) send(8'h10 + 8'(k));
    m.slot(1'b1, a);
    chk(ovf, 1);
    for (int k = 0; k < 9; k++) begin
      repeat (4) if (valid !== 1'b1) @(negedge mclk_i);
      chk({valid, data}, {1'b1, 8'h10 + 8'(k)});
      ready = 1'b1;
      @(negedge mclk_i);
      ready = 1'b0;
    end
    fast_reset();
    chk({ovf, fast}, 2'b01);
  endtask
  task automatic t_read_id;
    send(rom_cmd_pkg::CMD_READ_ID);
    for (int i = 0; i < 64; i++) begin
      m.slot(1'b1, a);
      chk(a, ID[i]);
    end
    fast_reset();
  endtask
  task automatic t_select;
    send(rom_cmd_pkg::CMD_MATCH);
    for (int i = 0; i < 64; i++) m.slot(ID[i], a);
    chk({sel, resel}, 2'b11);
    fast_reset();
    send(rom_cmd_pkg::CMD_RESUME);
    chk(sel, 1);
    fast_reset();
    send(rom_cmd_pkg::CMD_FAST_MATCH);
    m.slot(!ID[0], a);
    chk({sel, resel, fast}, 3'b001);
    fast_reset();
    send(rom_cmd_pkg::CMD_RESUME);
    chk(sel, 0);
    fast_reset();
  endtask
  // The choice at bit 3 differs, so from bit 4 on the device stays silent.
  task automatic t_search;
    send(rom_cmd_pkg::CMD_SEARCH);
    for (int i = 0; i < 5; i++) begin
      m.slot(1'b1, a);
      m.slot(1'b1, b);
      chk({a, b}, (i < 4) ? {ID[i], !ID[i]} : 2'b11);
      m.slot((i == 3) ? !ID[i] : ID[i], a);
    end
    chk(sel, 0);
  endtask
  task automatic t_long_reset;
    m.fast = 1'b0;
    m.bus_reset(3100, p);
    chk({p, fast}, 2'b10);
  endtask
  initial begin
    #1 rst_i = 1'b1;
    repeat (5) @(negedge mclk_i);
    rst_i = 1'b0;
    t_fast_skip();
    t_fifo();
    t_read_id();
    t_select();
    t_search();
    t_long_reset();
    results();
  end
  initial begin
    repeat (110000) @(posedge mclk_i);
    n_mismatch++;
    results();
  end
endmodule
bind rom_command_layer rom_cmd_layer_sva #(.SPEED_CLEAR_CYC(SPEED_CLEAR_CYC), .RST_STD_CYC(RST_STD_CYC)) chk_i (
  .mclk_i(mclk_i), .rst_i(rst_i), .dq_i(dq_i), .dq_oe_o(dq_oe_o), .func_data_o(func_data_o),
  .func_valid_o(func_valid_o), .func_ready_i(func_ready_i), .selected_o(selected_o),
  .fast_speed_flag_o(fast_speed_flag_o), .reselect_flag_o(reselect_flag_o), .overflow_o(overflow_o));
`default_nettype wire
